// >>> fwes_map.svh
// Constants for the filter wheel exposure sequencer.
`ifndef FWES_MAP_SVH
`define FWES_MAP_SVH
`define FWES_FILTER_HOME 2'h0
`define FWES_FILTER_RED 2'h1
`define FWES_FILTER_GREEN 2'h2
`define FWES_FILTER_BLUE 2'h3
`define FWES_SENSE_NONE 2'h0
`define FWES_SENSE_SINGLE 2'h1
`define FWES_SENSE_DOUBLE 2'h2
`define FWES_STEP_PERIOD_US 1000
`define FWES_CLK_MHZ 250
`define FWES_STEP_CYCLES (`FWES_STEP_PERIOD_US * `FWES_CLK_MHZ)
`define FWES_PAIR_WINDOW_NS 40000
`define FWES_PAIR_CYCLES (`FWES_PAIR_WINDOW_NS / 4)
`define FWES_PHASE_INIT 4'h1
`endif

// >>> fwes_pkg.sv
// Types for the filter wheel exposure sequencer.
package fwes_pkg;
  typedef enum logic [6:0] {
    FWES_ST_INIT = 7'b000_0001,
    FWES_ST_IDLE = 7'b000_0010,
    FWES_ST_HOME = 7'b000_0100,
    FWES_ST_SEEK = 7'b000_1000,
    FWES_ST_LOAD = 7'b001_0000,
    FWES_ST_SHIFT = 7'b010_0000,
    FWES_ST_DARK = 7'b100_0000
  } fwes_state_t;
endpackage : fwes_pkg

// >>> fwes_serializer.sv
// Word latch and shift register that turns image words into serial video.
`timescale 1ns/1ps
module fwes_serializer #(
  parameter int WIDTH = 16
) (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic load_in,
  input wire logic shift_in,
  input wire logic [WIDTH-1:0] word_in,
  output logic bit_out,
  output logic empty_out
);
  typedef struct packed {
    logic [WIDTH-1:0] shreg;
    logic [$clog2(WIDTH+1)-1:0] left;
  } fwes_ser_t;
  fwes_ser_t st;
  fwes_ser_t next_st;

  // Load latches a word; each shift sends the most significant bit first.
  always_comb begin
    next_st = st;
    if (load_in) begin
      next_st.shreg = word_in;
      next_st.left = ($clog2(WIDTH+1))'(WIDTH);
    end else if (shift_in && st.left != '0) begin
      next_st.shreg = {st.shreg[WIDTH-2:0], 1'b0};
      next_st.left = st.left - 1'b1;
    end
  end

  // State register.
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign bit_out = st.shreg[WIDTH-1];
  assign empty_out = (st.left == '0);
endmodule : fwes_serializer

// >>> fwes_sequencer.sv
// Filter wheel exposure sequencer: wheel positioning and video gating.
`timescale 1ns/1ps
`include "fwes_map.svh"
module fwes_sequencer #(
  parameter int WORD_WIDTH = 16,
  parameter int STEP_CYCLES = `FWES_STEP_CYCLES,
  parameter int PAIR_CYCLES = `FWES_PAIR_CYCLES
) (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic cmd_valid_in,
  input wire logic [1:0] cmd_filter_in,
  input wire logic full_colour_in,
  input wire logic [15:0] words_per_exposure_in,
  input wire logic [WORD_WIDTH-1:0] image_word_in,
  input wire logic wheel_position_pulse,
  output logic cmd_ready_out,
  output logic image_word_req_out,
  output logic [3:0] motor_phase_out,
  output logic video_out,
  output logic video_enable_out,
  output logic [1:0] current_filter_out,
  output logic [1:0] position_sense_out,
  output logic exposure_done_out
);
  localparam int SW = $clog2(STEP_CYCLES + 1);
  localparam int PW = $clog2(PAIR_CYCLES + 1);

  typedef struct packed {
    fwes_pkg::fwes_state_t state;
    logic [1:0] sync;
    logic pulse_prev;
    logic [SW-1:0] step_cnt;
    logic [3:0] phase;
    logic [PW-1:0] pair_cnt;
    logic pair_open;
    logic [1:0] sense;
    logic sense_valid;
    logic [1:0] cur;
    logic [1:0] target;
    logic auto_seq;
    logic [15:0] words_left;
    logic word_req;
    logic video;
    logic video_en;
    logic ready;
    logic done;
  } fwes_seq_t;

  fwes_seq_t st;
  fwes_seq_t next_st;
  logic ser_bit;
  logic ser_empty;
  logic ser_load;
  logic ser_shift;
  logic rise;
  logic step_tick;
  logic driving;

  assign rise = st.sync[1] && !st.pulse_prev;
  assign step_tick = (st.step_cnt == SW'(STEP_CYCLES - 1));
  assign driving = (st.state == fwes_pkg::FWES_ST_INIT) ||
                   (st.state == fwes_pkg::FWES_ST_HOME) ||
                   (st.state == fwes_pkg::FWES_ST_SEEK);
  assign ser_load = (st.state == fwes_pkg::FWES_ST_LOAD);
  assign ser_shift = (st.state == fwes_pkg::FWES_ST_SHIFT);

  // Latch and serialize each image word.
  fwes_serializer #(
    .WIDTH(WORD_WIDTH)
  ) u_ser (
    .ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in),
    .load_in(ser_load),
    .shift_in(ser_shift),
    .word_in(image_word_in),
    .bit_out(ser_bit),
    .empty_out(ser_empty)
  );

  // Next-state logic for sensing, stepping and exposure.
  always_comb begin
    next_st = st;
    next_st.sync = {st.sync[0], wheel_position_pulse};
    next_st.pulse_prev = st.sync[1];
    next_st.sense_valid = 1'b0;
    next_st.word_req = 1'b0;
    next_st.done = 1'b0;
    // One pulse opens a window; a second inside it means home.
    if (st.pair_open) begin
      if (rise) begin
        next_st.sense = `FWES_SENSE_DOUBLE;
        next_st.sense_valid = 1'b1;
        next_st.pair_open = 1'b0;
      end else if (st.pair_cnt == PW'(PAIR_CYCLES - 1)) begin
        next_st.sense = `FWES_SENSE_SINGLE;
        next_st.sense_valid = 1'b1;
        next_st.pair_open = 1'b0;
      end else begin
        next_st.pair_cnt = st.pair_cnt + 1'b1;
      end
    end else if (rise) begin
      next_st.pair_open = 1'b1;
      next_st.pair_cnt = '0;
    end
    // Track wheel position from decoded sense.
    if (st.sense_valid) begin
      if (st.sense == `FWES_SENSE_DOUBLE) begin
        next_st.cur = `FWES_FILTER_HOME;
      end else begin
        next_st.cur = st.cur + 1'b1;
      end
    end
    // Step divider and clockwise-only phase rotation.
    if (driving) begin
      next_st.step_cnt = step_tick ? '0 : st.step_cnt + 1'b1;
      if (step_tick) begin
        next_st.phase = {st.phase[2:0], st.phase[3]};
      end
    end else begin
      next_st.step_cnt = '0;
    end
    next_st.video_en = 1'b0;
    next_st.video = 1'b0;
    next_st.ready = 1'b0;
    case (st.state)
      fwes_pkg::FWES_ST_INIT: begin
        if (st.sense_valid && st.sense == `FWES_SENSE_DOUBLE) begin
          next_st.state = fwes_pkg::FWES_ST_IDLE;
          next_st.phase = st.phase;
          next_st.ready = 1'b1;
        end
      end
      fwes_pkg::FWES_ST_IDLE: begin
        next_st.ready = 1'b1;
        if (cmd_valid_in && st.ready) begin
          next_st.ready = 1'b0;
          next_st.auto_seq = full_colour_in;
          next_st.target = full_colour_in ? `FWES_FILTER_RED :
                           cmd_filter_in;
          if ((full_colour_in ? `FWES_FILTER_RED : cmd_filter_in) <
              st.cur) begin
            next_st.state = fwes_pkg::FWES_ST_HOME;
          end else begin
            next_st.state = fwes_pkg::FWES_ST_SEEK;
          end
        end
      end
      fwes_pkg::FWES_ST_HOME: begin
        if (st.sense_valid && st.sense == `FWES_SENSE_DOUBLE) begin
          next_st.state = fwes_pkg::FWES_ST_SEEK;
        end
      end
      fwes_pkg::FWES_ST_SEEK: begin
        if (st.cur == st.target && !st.pair_open) begin
          next_st.state = fwes_pkg::FWES_ST_LOAD;
          // A step due on this same edge is dropped so the wheel halts here.
          next_st.phase = st.phase;
          next_st.step_cnt = '0;
          next_st.words_left = words_per_exposure_in;
          next_st.word_req = 1'b1;
        end
      end
      fwes_pkg::FWES_ST_LOAD: begin
        // Video stays dark while the word is latched; shifting shows it.
        next_st.state = fwes_pkg::FWES_ST_SHIFT;
      end
      fwes_pkg::FWES_ST_SHIFT: begin
        next_st.video_en = 1'b1;
        next_st.video = ser_bit;
        if (ser_empty || st.words_left == 16'h0000) begin
          next_st.video_en = 1'b0;
          next_st.video = 1'b0;
          if (st.words_left > 16'h0001) begin
            next_st.words_left = st.words_left - 1'b1;
            next_st.word_req = 1'b1;
            next_st.state = fwes_pkg::FWES_ST_LOAD;
          end else begin
            next_st.state = fwes_pkg::FWES_ST_DARK;
          end
        end
      end
      fwes_pkg::FWES_ST_DARK: begin
        next_st.done = 1'b1;
        if (st.auto_seq && st.target != `FWES_FILTER_BLUE) begin
          next_st.target = st.target + 1'b1;
          next_st.state = fwes_pkg::FWES_ST_SEEK;
        end else begin
          next_st.state = fwes_pkg::FWES_ST_IDLE;
          next_st.ready = 1'b1;
        end
      end
      default: begin
        next_st.state = fwes_pkg::FWES_ST_INIT;
      end
    endcase
  end

  // State register.
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st <= '0;
      st.state <= fwes_pkg::FWES_ST_INIT;
      st.phase <= `FWES_PHASE_INIT;
    end else begin
      st <= next_st;
    end
  end

  assign cmd_ready_out = st.ready;
  assign image_word_req_out = st.word_req;
  assign motor_phase_out = st.phase;
  assign video_out = st.video;
  assign video_enable_out = st.video_en;
  assign current_filter_out = st.cur;
  assign position_sense_out = st.sense;
  assign exposure_done_out = st.done;

  // Video is dark while the wheel is driven.
  chk_dark_moving: assert property (
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    driving |=> !video_enable_out)
    else $error("Video enabled while wheel moving.");
  // Exposure starts only at the requested filter.
  chk_exposure_position: assert property (
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    $rose(video_enable_out) |-> current_filter_out == st.target)
    else $error("Exposure started at wrong filter.");
  // Phases only rotate one way.
  chk_phase_cw: assert property (
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    $changed(motor_phase_out) |->
      motor_phase_out == {$past(motor_phase_out[2:0]),
                          $past(motor_phase_out[3])})
    else $error("Motor phase stepped backwards.");
  // Double notch clears position.
  chk_home_clear: assert property (
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    st.sense_valid && st.sense == `FWES_SENSE_DOUBLE |=>
      current_filter_out == `FWES_FILTER_HOME)
    else $error("Home not cleared position.");
  // Motor stops when matched.
  chk_stop_match: assert property (
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    st.state == fwes_pkg::FWES_ST_LOAD |-> $stable(motor_phase_out))
    else $error("Stepping during exposure.");
  // Lower request goes via home.
  chk_lower_home: assert property (
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    st.state == fwes_pkg::FWES_ST_IDLE && cmd_valid_in && st.ready &&
      !full_colour_in && cmd_filter_in < st.cur |=>
      st.state == fwes_pkg::FWES_ST_HOME)
    else $error("Lower request skipped home.");
  // No command taken before homing.
  chk_init_ready: assert property (
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    st.state == fwes_pkg::FWES_ST_INIT |-> !cmd_ready_out)
    else $error("Ready before home found.");
  // Exposure end darkens video.
  chk_dark_end: assert property (
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    st.state == fwes_pkg::FWES_ST_DARK |-> !video_enable_out)
    else $error("Video on after exposure.");
  // An accepted command drops ready on the next cycle.
  chk_ready_drop: assert property (
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    st.state == fwes_pkg::FWES_ST_IDLE && cmd_valid_in && st.ready |=>
      !cmd_ready_out)
    else $error("Ready held after command taken.");
  // A request at or above the current filter steps straight forward.
  chk_higher_direct: assert property (
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    st.state == fwes_pkg::FWES_ST_IDLE && cmd_valid_in && st.ready &&
      !full_colour_in && cmd_filter_in >= st.cur |=>
      st.state == fwes_pkg::FWES_ST_SEEK)
    else $error("Higher request went via home.");
  // A full colour run starts with red.
  chk_red_first: assert property (
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    st.state == fwes_pkg::FWES_ST_IDLE && cmd_valid_in && st.ready &&
      full_colour_in |=> st.target == `FWES_FILTER_RED)
    else $error("Full colour run did not start with red.");
  // Each colour of a full run before blue is followed by the next one.
  chk_next_colour: assert property (
    @(posedge ref_clk_in) disable iff (!reset_n_in)
    st.state == fwes_pkg::FWES_ST_DARK && st.auto_seq &&
      st.target != `FWES_FILTER_BLUE |=>
      st.state == fwes_pkg::FWES_ST_SEEK &&
      st.target == $past(st.target) + 2'h1)
    else $error("Full colour run skipped a colour.");
  cov_home: cover property (@(posedge ref_clk_in)
    st.state == fwes_pkg::FWES_ST_HOME ##1
    st.state == fwes_pkg::FWES_ST_SEEK);
  cov_expose: cover property (@(posedge ref_clk_in) $rose(video_enable_out));
  cov_blue_done: cover property (@(posedge ref_clk_in)
    exposure_done_out && st.target == `FWES_FILTER_BLUE);
endmodule : fwes_sequencer

// >>> fwes_wheel_model.sv
// Behavioural filter wheel with stepper and photo interrupter sense.
`timescale 1ns/1ps
module fwes_wheel_model #(
  parameter int STEPS_PER_FILTER = 4,
  parameter int START_STEP = 1
) (
  input wire logic ref_clk_in,
  input wire logic [3:0] motor_phase_in,
  output logic wheel_position_pulse_out,
  output int home_passes_out
);
  int step = START_STEP;
  logic [3:0] last_phase = 4'h1;
  logic [5:0] pattern = 6'h00;
  int next_step;

  // Each phase change moves the wheel one step; notches start pulse bursts.
  always @(posedge ref_clk_in) begin
    pattern <= {1'b0, pattern[5:1]};
    if (motor_phase_in !== last_phase) begin
      last_phase <= motor_phase_in;
      next_step = (step + 1) % (4 * STEPS_PER_FILTER);
      step <= next_step;
      if (next_step == 0) begin
        pattern <= 6'h05;
        home_passes_out <= home_passes_out + 1;
      end else if (next_step % STEPS_PER_FILTER == 0) begin
        pattern <= 6'h03;
      end
    end
  end

  // The sensor output is low whenever no notch is in the light path.
  assign wheel_position_pulse_out = pattern[0];

  initial home_passes_out = 0;
endmodule : fwes_wheel_model

// >>> fwes_sequencer_tb.sv
// Self-checking testbench for the filter wheel exposure sequencer.
`timescale 1ns/1ps
module fwes_sequencer_tb;
  localparam int W = 8;
  localparam logic [7:0] WORD = 8'hB4;
  logic ref_clk_in, reset_n_in, cmd_valid_in, full_colour_in, pulse;
  logic [1:0] cmd_filter_in, cur, sense;
  logic [15:0] words_per_exposure_in;
  logic [W-1:0] image_word_in, seen_bits;
  logic ready, req, vid, ven, done;
  logic [3:0] phase, prev_phase;
  int home_passes, num_errors, num_checks, dones, hits, h0, bits;
  logic [1:0] order_q[$];

  fwes_sequencer #(.WORD_WIDTH(W), .STEP_CYCLES(16), .PAIR_CYCLES(4)) dut (
    .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
    .cmd_valid_in(cmd_valid_in), .cmd_filter_in(cmd_filter_in),
    .full_colour_in(full_colour_in),
    .words_per_exposure_in(words_per_exposure_in),
    .image_word_in(image_word_in), .wheel_position_pulse(pulse),
    .cmd_ready_out(ready), .image_word_req_out(req),
    .motor_phase_out(phase), .video_out(vid), .video_enable_out(ven),
    .current_filter_out(cur), .position_sense_out(sense),
    .exposure_done_out(done));

  fwes_wheel_model #(.STEPS_PER_FILTER(4), .START_STEP(1)) wheel (
    .ref_clk_in(ref_clk_in), .motor_phase_in(phase),
    .wheel_position_pulse_out(pulse), .home_passes_out(home_passes));

  // Clock generation at 250 MHz.
  initial begin
    ref_clk_in = 1'b0;
    forever #2 ref_clk_in = ~ref_clk_in;
  end

  // Compares a seen value with the expected one and counts both outcomes.
  task check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Image word is valid from the falling edge inside a request cycle, inverted otherwise.
  always @(negedge ref_clk_in) begin
    image_word_in <= (req === 1'b1) ? WORD : ~WORD;
  end

  // Watches video bits, done pulses and motor steps.
  always @(posedge ref_clk_in) begin
    if (ven === 1'b1) begin
      seen_bits <= {seen_bits[W-2:0], vid};
      bits <= bits + 1;
      if ({seen_bits[W-2:0], vid} === WORD) hits <= hits + 1;
    end
    if (done === 1'b1) begin
      dones <= dones + 1;
      order_q.push_back(cur);
    end
    if (reset_n_in === 1'b1 && phase !== prev_phase) begin
      check(16'(phase), 16'({prev_phase[2:0], prev_phase[3]}));
      check(16'(ven), 16'h0000);
    end
    prev_phase <= phase;
  end

  // Waits until the sequencer is idle again, bounded.
  task wait_idle;
    int n;
    n = 0;
    repeat (2) @(negedge ref_clk_in);
    while (ready !== 1'b1 && n < 5000) begin
      @(negedge ref_clk_in);
      n++;
    end
    // One more edge lets the watcher count the final done pulse.
    @(negedge ref_clk_in);
    check(16'(ready), 16'h0001);
  endtask : wait_idle

  // Issues one command and waits for its whole sequence.
  task send(input logic [1:0] f, input logic full);
    @(negedge ref_clk_in);
    cmd_filter_in = f;
    full_colour_in = full;
    cmd_valid_in = 1'b1;
    @(negedge ref_clk_in);
    cmd_valid_in = 1'b0;
    wait_idle();
  endtask : send

  // Reset values, then homing before the first command.
  task t_reset;
    reset_n_in = 1'b0;
    repeat (10) @(negedge ref_clk_in);
    check(16'(phase), 16'h0001);
    check(16'({ready, ven, done, cur}), 16'h0000);
    reset_n_in = 1'b1;
    wait_idle();
    check(16'(cur), 16'h0000);
    check(16'(sense), 16'h0002);
    check(16'(home_passes), 16'h0001);
    $display("test reset done");
  endtask : t_reset

  // Single colour exposure with an expected count of home passes.
  task t_single(input logic [1:0] f, input int homes);
    h0 = home_passes;
    hits = 0;
    dones = 0;
    bits = 0;
    send(f, 1'b0);
    check(16'(cur), 16'(f));
    check(16'(sense), 16'h0001);
    check(16'(home_passes - h0), 16'(homes));
    check(16'(dones), 16'h0001);
    check(16'(hits), 16'h0002);
    check(16'(bits), 16'(W * 2));
    check(16'(ven), 16'h0000);
    $display("test single filter %0d done", f);
  endtask : t_single

  // Full colour run: red, green and blue in turn.
  task t_full;
    dones = 0;
    hits = 0;
    bits = 0;
    order_q.delete();
    send(2'h0, 1'b1);
    check(16'(dones), 16'h0003);
    check(16'(hits), 16'h0006);
    check(16'(bits), 16'(W * 6));
    for (int i = 0; i < 3; i++) begin
      check(16'(order_q[i]), 16'(i + 1));
    end
    $display("test full colour done");
  endtask : t_full

  // Prints the counts and the verdict, then ends the run.
  task close_out;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out

  // Watchdog cuts a hang short.
  initial begin
    #100000;
    num_errors++;
    close_out();
  end

  // Main sequence of tests.
  initial begin
    num_errors = 0;
    num_checks = 0;
    dones = 0;
    hits = 0;
    bits = 0;
    prev_phase = 4'h1;
    seen_bits = 8'h00;
    reset_n_in = 1'b0;
    cmd_valid_in = 1'b0;
    cmd_filter_in = 2'h0;
    full_colour_in = 1'b0;
    words_per_exposure_in = 16'h0002;
    image_word_in = ~WORD;
    t_reset();
    t_single(2'h2, 0);
    t_single(2'h1, 1);
    t_single(2'h3, 0);
    t_full();
    close_out();
  end
endmodule : fwes_sequencer_tb
